// ---- logic/lp_pkg.sv ----
package lp_pkg;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] cmd_off = 8'h08;
  localparam logic [7:0] err_off = 8'h0c;

  // ==========================================================
  // Control register fields
  // ==========================================================
  localparam int ctrl_ready_bit = 0;
  localparam int ctrl_manual_bit = 1;
  localparam int ctrl_format_bit = 2;
  localparam int ctrl_tape_bit = 3;
  localparam int ctrl_interlace_bit = 4;
  localparam int ctrl_connected_bit = 5;
  localparam logic [31:0] ctrl_reset_val = 32'h0000_0020;

  // ==========================================================
  // Command register fields (write-only strobes)
  // ==========================================================
  localparam int cmd_output_bit = 0;
  localparam int cmd_offline_bit = 1;
  localparam int cmd_term_bit = 2;
  localparam int cmd_endline_bit = 3;

  // ==========================================================
  // Status register fields
  // ==========================================================
  localparam int st_fault_bit = 0;
  localparam int st_offline_bit = 1;
  localparam int st_busy_bit = 2;
  localparam int st_reread_bit = 3;
  localparam int st_wait_bit = 4;

  // ==========================================================
  // Character codes
  // ==========================================================
  localparam logic [5:0] eof_code = 6'h0f;
  localparam logic [5:0] nospace_code = 6'h20;
  localparam logic [2:0] fmt_upspace_tag = 3'h4;
  localparam logic [2:0] fmt_skip_tag = 3'h0;

  localparam logic [1:0] axi_okay = 2'h0;
  localparam logic [1:0] axi_slverr = 2'h2;

  typedef enum {
    st_online,
    st_wait_start,
    st_rec_first,
    st_rec_body,
    st_rec_reread,
    st_hopper_wait,
    st_finish
  } coupler_state_t;

  typedef struct packed {
    logic [5:0] data;
    logic parity_err;
    logic first;
    logic last;
  } src_char_t;

  typedef struct packed {
    logic skip;
    logic [2:0] amount;
  } space_cmd_t;

endpackage : lp_pkg

// ---- logic/err_sticky.sv ----
`timescale 1ns/10ps
module err_sticky
  import lp_pkg::*;
#(
  parameter int width = 3
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Events and clears
  input wire logic [width-1:0] set_in,
  input wire logic clear,
  // State
  output logic [width-1:0] flags
);

  // ==========================================================
  // Sticky flags
  // ==========================================================
  // A set arriving with the clear wins, so no event is lost.
  logic [width-1:0] flags_ff;
  assign flags = flags_ff;

  generate
    for (genvar i = 0; i < width; i++) begin : g_flag
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flags_ff[i] <= 1'b0;
        end else if (set_in[i]) begin
          flags_ff[i] <= 1'b1;
        end else if (clear) begin
          flags_ff[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : err_sticky

// ---- logic/line_printer_ctl.sv ----
`timescale 1ns/10ps
// Overview of operation
// - Interlaced output raises terminate-output internally at line end.
// - Hammer-path parity error sets the print fault flag.
// - Buffer parity or rate error sets the buffer error flag.
// - Source parity error sets input fault only while off-line.
// - Off-line characters flow source to printer, channel side untouched.
// - Off-line job is source-paced until end-of-file.
// - Tape parity error sets fault and rereads the record once.
// - Reread error sets fault, ends job, returns on-line.
// - Card validity error sets fault, ends job, returns on-line.
// - An output command while on-line clears the fault flag.
// - Format codes 00-07 skip to channel, 40 no space, 41-47 upspace.
// - Off-line spacing: single upspace or format character.
// - At job end a connected printer returns on-line unless manual.
// - Ready rising after off-line selection starts transfer.
// - Tape record whose first character is octal 17 ends the job.
// - Card end-of-file needs empty hopper and enable on.
// - Empty hopper without enable waits for the reader.
// - Printing waits for upspace end; line data buffers meanwhile.
// - End-of-record pulses only after fetch done and line printed.
// - Format mode takes each record's first character as format.
module line_printer_ctl
  import lp_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Printer mechanism
  input wire logic hammer_parity_err,
  input wire logic buf_parity_err,
  input wire logic rate_err,
  input wire logic upspace_busy,
  input wire logic line_printed,
  input wire logic fetch_done,
  output logic print_start,
  output logic space_valid,
  output space_cmd_t space_cmd,
  output logic terminate_output,
  output logic end_of_record,
  // Off-line source
  input wire logic src_valid,
  input wire src_char_t src_char,
  input wire logic card_hopper_empty,
  input wire logic card_eof_enable,
  input wire logic card_reader_ready,
  input wire logic card_validity_err,
  output logic src_ready,
  output logic src_reread,
  output logic src_offline,
  // Off-line character path to printer buffer
  output logic pr_char_valid,
  output logic [5:0] pr_char,
  output logic pr_line_end
);

  // ==========================================================
  // Synchronisers for mechanism and source pins
  // ==========================================================
  logic [7:0] pin_s1_ff;
  logic [7:0] pin_s2_ff;
  wire logic [7:0] pin_raw = {hammer_parity_err, buf_parity_err, rate_err,
    upspace_busy, card_hopper_empty, card_eof_enable, card_reader_ready,
    card_validity_err};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_ff <= 8'h00;
      pin_s2_ff <= 8'h00;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
    end
  end
  wire logic hammer_err_s = pin_s2_ff[7];
  wire logic buf_err_s = pin_s2_ff[6] | pin_s2_ff[5];
  wire logic upspace_s = pin_s2_ff[4];
  wire logic hopper_empty_s = pin_s2_ff[3];
  wire logic eof_en_s = pin_s2_ff[2];
  wire logic reader_ready_s = pin_s2_ff[1];
  wire logic validity_err_s = pin_s2_ff[0];

  // ==========================================================
  // AXI4-Lite slave
  // ==========================================================
  // Address and data latch separately, in either order.
  logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [31:0] ctrl_ff, rdata_ff;
  logic [1:0] bresp_ff, rresp_ff;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  wire logic wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  wire logic wr_ctrl = wr_fire && awaddr_ff == ctrl_off;
  wire logic wr_cmd = wr_fire && awaddr_ff == cmd_off;
  wire logic wr_known = awaddr_ff == ctrl_off || awaddr_ff == cmd_off ||
    awaddr_ff == status_off || awaddr_ff == err_off;
  logic wstrb_lo;
  wire logic cmd_ok = wr_cmd && wstrb_lo;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_lo <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_lo <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= axi_okay;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_known ? axi_okay : axi_slverr;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= ctrl_reset_val;
    end else if (wr_ctrl && wstrb_lo) begin
      ctrl_ff <= {26'h0, wdata_ff[5:0]};
    end
  end

  wire logic ready_sw = ctrl_ff[ctrl_ready_bit];
  wire logic manual = ctrl_ff[ctrl_manual_bit];
  wire logic fmt_mode = ctrl_ff[ctrl_format_bit];
  wire logic src_tape = ctrl_ff[ctrl_tape_bit];
  wire logic interlace = ctrl_ff[ctrl_interlace_bit];
  wire logic connected = ctrl_ff[ctrl_connected_bit];
  wire logic cmd_output = cmd_ok && wdata_ff[cmd_output_bit];
  wire logic cmd_offline = cmd_ok && wdata_ff[cmd_offline_bit];
  wire logic cmd_term = cmd_ok && wdata_ff[cmd_term_bit];
  wire logic cmd_endline = cmd_ok && wdata_ff[cmd_endline_bit];

  // ==========================================================
  // Ready toggling and error flags
  // ==========================================================
  logic ready_d_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_d_ff <= 1'b0;
    end else begin
      ready_d_ff <= ready_sw;
    end
  end
  wire logic ready_rise = ready_sw && !ready_d_ff;
  wire logic ready_fall = !ready_sw && ready_d_ff;

  coupler_state_t state_ff, nxt_state;
  logic reread_ff, nxt_reread;
  logic fault_set;
  wire logic offline = state_ff != st_online;
  wire logic src_par = src_valid && src_char.parity_err;
  logic [2:0] flags;

  // Clear by output command on-line, or by dropping ready.
  wire logic fault_clr = (cmd_output && !offline) || ready_fall;

  err_sticky #(
    .width(3)
  ) u_err (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_in({offline && src_par, buf_err_s, hammer_err_s | fault_set}),
    .clear(fault_clr),
    .flags(flags)
  );

  // ==========================================================
  // Off-line coupler sequencer
  // ==========================================================
  wire logic src_fire = src_valid && src_ready;
  wire logic fmt_char = fmt_mode && src_char.first;
  wire logic tape_eof = src_tape && src_char.first &&
    src_char.data == eof_code;
  wire logic card_eof = !src_tape && hopper_empty_s && eof_en_s;
  wire logic card_wait = !src_tape && hopper_empty_s && !eof_en_s;

  always_comb begin
    nxt_state = state_ff;
    nxt_reread = reread_ff;
    fault_set = 1'b0;
    unique case (state_ff)
      st_online: begin
        if (cmd_offline) begin
          nxt_state = ready_sw ? st_rec_first : st_wait_start;
        end
        nxt_reread = 1'b0;
      end
      st_wait_start: begin
        if (ready_rise) begin
          nxt_state = st_rec_first;
        end
      end
      st_rec_first, st_rec_body: begin
        if (card_eof) begin
          nxt_state = st_finish;
        end else if (card_wait) begin
          nxt_state = st_hopper_wait;
        end else if (!src_tape && validity_err_s) begin
          fault_set = 1'b1;
          nxt_state = st_finish;
        end else if (src_fire && tape_eof) begin
          nxt_state = st_finish;
        end else if (src_fire && src_tape && src_char.parity_err) begin
          fault_set = 1'b1;
          nxt_state = reread_ff ? st_finish : st_rec_reread;
          nxt_reread = !reread_ff;
        end else if (src_fire && src_char.last) begin
          nxt_state = st_rec_first;
          nxt_reread = 1'b0;
        end else if (src_fire) begin
          nxt_state = st_rec_body;
        end
      end
      st_rec_reread: begin
        nxt_state = st_rec_first;
      end
      st_hopper_wait: begin
        if (card_eof) begin
          nxt_state = st_finish;
        end else if (reader_ready_s && !hopper_empty_s) begin
          nxt_state = st_rec_first;
        end
      end
      st_finish: begin
        if (connected && !manual) begin
          nxt_state = st_online;
        end
      end
    endcase
    if (ready_fall && offline) begin
      nxt_state = st_online;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= st_online;
      reread_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      reread_ff <= nxt_reread;
    end
  end

  // ==========================================================
  // Character path and vertical format
  // ==========================================================
  // The source is stalled while an upspace runs so the buffer never
  // takes more than one line ahead of the paper.
  wire logic pass_state = state_ff == st_rec_first ||
    state_ff == st_rec_body;
  assign src_ready = pass_state && !upspace_s;
  assign src_offline = offline;

  logic pr_valid_ff, pr_end_ff, reread_pulse_ff, space_valid_ff;
  logic [5:0] pr_char_ff;
  space_cmd_t space_ff;
  wire logic good_char = src_fire && !src_char.parity_err && !tape_eof;
  wire logic fmt_up = src_char.data[5:3] == fmt_upspace_tag;
  wire logic fmt_skip = src_char.data[5:3] == fmt_skip_tag;
  wire logic space_from_fmt = good_char && fmt_char &&
    src_char.data != nospace_code && (fmt_up || fmt_skip);
  wire logic space_single = good_char && !fmt_mode && src_char.last;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pr_valid_ff <= 1'b0;
      pr_end_ff <= 1'b0;
      pr_char_ff <= 6'h00;
      space_valid_ff <= 1'b0;
      space_ff <= '0;
      reread_pulse_ff <= 1'b0;
    end else begin
      pr_valid_ff <= good_char && !fmt_char;
      pr_end_ff <= good_char && src_char.last;
      pr_char_ff <= src_char.data;
      space_valid_ff <= space_from_fmt || space_single;
      if (space_from_fmt) begin
        space_ff <= '{skip: fmt_skip, amount: src_char.data[2:0]};
      end else if (space_single) begin
        space_ff <= '{skip: 1'b0, amount: 3'h1};
      end
      reread_pulse_ff <= state_ff == st_rec_reread;
    end
  end
  assign pr_char_valid = pr_valid_ff;
  assign pr_char = pr_char_ff;
  assign pr_line_end = pr_end_ff;
  assign space_valid = space_valid_ff;
  assign space_cmd = space_ff;
  assign src_reread = reread_pulse_ff;

  // ==========================================================
  // On-line line completion
  // ==========================================================
  logic line_pend_ff, print_pend_ff, fetch_seen_ff, print_go_ff;
  logic term_ff, eor_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_pend_ff <= 1'b0;
      print_pend_ff <= 1'b0;
      fetch_seen_ff <= 1'b0;
      print_go_ff <= 1'b0;
      term_ff <= 1'b0;
      eor_ff <= 1'b0;
    end else begin
      term_ff <= (cmd_endline && interlace) || cmd_term;
      print_go_ff <= print_pend_ff && !upspace_s;
      if (print_pend_ff && !upspace_s) begin
        print_pend_ff <= 1'b0;
      end else if (cmd_endline || cmd_term) begin
        print_pend_ff <= 1'b1;
      end
      if (cmd_output && !offline) begin
        line_pend_ff <= 1'b1;
        fetch_seen_ff <= 1'b0;
      end else if (line_pend_ff && fetch_seen_ff && line_printed) begin
        line_pend_ff <= 1'b0;
      end else if (fetch_done) begin
        fetch_seen_ff <= 1'b1;
      end
      eor_ff <= line_pend_ff && fetch_seen_ff && line_printed;
    end
  end
  assign print_start = print_go_ff;
  assign terminate_output = term_ff;
  assign end_of_record = eor_ff;

  // ==========================================================
  // Read path
  // ==========================================================
  wire logic [31:0] status_word = {27'h0, state_ff == st_hopper_wait,
    reread_ff, line_pend_ff, offline, flags[0]};
  wire logic rd_known = s_axi_araddr == ctrl_off ||
    s_axi_araddr == status_off || s_axi_araddr == err_off ||
    s_axi_araddr == cmd_off;
  wire logic [31:0] rd_word = s_axi_araddr == ctrl_off ? ctrl_ff :
    s_axi_araddr == status_off ? status_word :
    s_axi_araddr == err_off ? {29'h0, flags} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= axi_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_known ? axi_okay : axi_slverr;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule : line_printer_ctl

// ---- sim/src_model.sv ----
`timescale 1ns/10ps
// ======
// Card or tape source
module src_model
  import lp_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Character stream
  input wire logic src_ready,
  output logic src_valid,
  output src_char_t src_char
);
  initial begin
    src_valid = 1'b0;
    src_char = '0;
  end
  // Each character stands until taken, so src_ready sets the pace.
  task automatic put(input src_char_t c, output bit ok);
    int i;
    bit t;
    src_valid <= 1'b1;
    src_char <= c;
    t = 1'b0;
    for (i = 0; i < 400 && !t; i++) begin
      @(negedge aclk);
      t = (src_ready === 1'b1);
      @(posedge aclk);
    end
    ok = t;
  endtask : put
  task automatic send_rec(input logic [5:0] a, input logic [5:0] b,
                          input bit two, input bit perr, output bit ok);
    src_char_t c;
    @(posedge aclk);
    c = '{data: a, parity_err: 1'b0, first: 1'b1, last: !two};
    put(c, ok);
    if (two && ok) begin
      c = '{data: b, parity_err: perr, first: 1'b0, last: 1'b1};
      put(c, ok);
    end
    // Released data shows the inverse so a stale value cannot pass.
    src_valid <= 1'b0;
    src_char <= src_char_t'(~c);
  endtask : send_rec
endmodule : src_model

// ---- sim/lp_ctl_monitor.sv ----
`timescale 1ns/10ps
// ======
// Port checker
module lp_ctl_monitor
  import lp_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Printer and source
  input wire logic upspace_busy,
  input wire logic line_printed,
  input wire logic print_start,
  input wire logic terminate_output,
  input wire logic end_of_record,
  input wire logic src_valid,
  input wire src_char_t src_char,
  input wire logic src_ready,
  input wire logic src_offline,
  input wire logic pr_char_valid,
  input wire logic [5:0] pr_char
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_data_take;
    src_valid && src_ready && !src_char.first && !src_char.parity_err;
  endsequence
  sequence s_r_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp dropped");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_r_hold: assert property (s_r_wait |=> s_axi_rvalid)
    else $error("rvalid dropped");
  a_char_pass: assert property (s_data_take |=>
    pr_char_valid && pr_char == $past(src_char.data))
    else $error("char not passed");
  a_pr_offline: assert property (pr_char_valid |->
    $past(src_offline)) else $error("char on-line");
  a_ready_offline: assert property (src_ready |-> src_offline)
    else $error("ready on-line");
  a_eor_cause: assert property (end_of_record |->
    $past(line_printed)) else $error("stray eor");
  a_start_idle: assert property (print_start |->
    !$past(upspace_busy, 3)) else $error("start in upspace");
  a_term_pulse: assert property (terminate_output |=>
    !terminate_output) else $error("term too long");
endmodule : lp_ctl_monitor

bind line_printer_ctl lp_ctl_monitor i_lp_ctl_monitor (.*);

// ---- sim/offline_line_printer_control_tb_top.sv ----
`timescale 1ns/10ps
module offline_line_printer_control_tb_top;
  import lp_pkg::*;
  // ======
  // Signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic hammer_parity_err = 1'b0, buf_parity_err = 1'b0, rate_err = 1'b0;
  logic upspace_busy = 1'b0, line_printed = 1'b0, fetch_done = 1'b0;
  logic card_hopper_empty = 1'b0, card_eof_enable = 1'b0;
  logic card_reader_ready = 1'b1, card_validity_err = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, print_start, space_valid, terminate_output;
  logic end_of_record, src_valid, src_ready, src_reread, src_offline;
  logic pr_char_valid, pr_line_end;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [5:0] pr_char, last_pr;
  space_cmd_t space_cmd, last_sp;
  src_char_t src_char;
  int err_total, total_checks;
  int n_term, n_start, n_eor, n_sp, n_pr, n_rr;
  // Row: code, space expected, skip, amount.
  localparam logic [10:0] rows [16] = '{
    {6'h00, 5'h18}, {6'h01, 5'h19}, {6'h02, 5'h1a}, {6'h03, 5'h1b},
    {6'h04, 5'h1c}, {6'h05, 5'h1d}, {6'h06, 5'h1e}, {6'h07, 5'h1f},
    {6'h20, 5'h00}, {6'h21, 5'h11}, {6'h22, 5'h12}, {6'h23, 5'h13},
    {6'h24, 5'h14}, {6'h25, 5'h15}, {6'h26, 5'h16}, {6'h27, 5'h17}};
  always #20 aclk = ~aclk;
  line_printer_ctl i_line_printer_ctl (.*);
  src_model i_src_model (.*);
  always @(posedge aclk) begin
    if (terminate_output === 1'b1) n_term++;
    if (print_start === 1'b1) n_start++;
    if (end_of_record === 1'b1) n_eor++;
    if (src_reread === 1'b1) n_rr++;
    if (pr_char_valid === 1'b1) begin
      n_pr++;
      last_pr = pr_char;
    end
    if (space_valid === 1'b1) begin
      n_sp++;
      last_sp = space_cmd;
    end
  end
  // ======
  // Shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic timeout();
    chk(32'h0, 32'h1);
    report_and_stop();
  endtask : timeout
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                        output logic [1:0] r);
    bit aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    timeout();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    bit ar, rv;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (rv) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    timeout();
  endtask : axi_rd
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] r;
    axi_wr(a, v, r);
    chk(r, axi_okay);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(r, axi_okay);
  endtask : rd
  task automatic send(input logic [5:0] a, input logic [5:0] b,
                      input bit two, input bit perr);
    bit ok;
    i_src_model.send_rec(a, b, two, perr, ok);
    if (!ok) timeout();
  endtask : send
  task automatic wait_cnt(ref int c, input int b);
    for (int i = 0; i < 200 && c == b; i++) @(posedge aclk);
    if (c == b) timeout();
  endtask : wait_cnt
  task automatic wait_off(input logic v);
    for (int i = 0; i < 200 && src_offline !== v; i++) @(posedge aclk);
    if (src_offline !== v) timeout();
  endtask : wait_off
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset
  initial begin
    repeat (100000) @(posedge aclk);
    timeout();
  end
  // ======
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int k, bp, bs;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    wr(ctrl_off, 32'h0000_002d);
    rd(ctrl_off, d);
    chk(d[ctrl_ready_bit], 1'b1);
    wr(cmd_off, 32'h0000_0002);
    wait_off(1'b1);
    for (k = 0; k < 16; k++) begin
      bp = n_pr;
      bs = n_sp;
      send(rows[k][10:5], 6'h15, 1'b1, 1'b0);
      wait_cnt(n_pr, bp);
      if (rows[k][4]) wait_cnt(n_sp, bs);
      chk(n_pr - bp, 1);
      chk(last_pr, 6'h15);
      chk(n_sp - bs, rows[k][4]);
      if (rows[k][4]) chk(last_sp, rows[k][3:0]);
    end
    $display("done: format rows");
    send(eof_code, 6'h00, 1'b0, 1'b0);
    wait_off(1'b0);
    chk(src_offline, 1'b0);
    wr(cmd_off, 32'h0000_0002);
    wait_off(1'b1);
    for (k = 0; k < 2; k++) begin
      bp = n_rr;
      send(6'h21, 6'h15, 1'b1, 1'b1);
      wait_cnt(n_rr, bp);
      chk(n_rr - bp, 1);
      send(6'h21, 6'h15, 1'b1, k == 1);
      wait_off(k == 0);
      chk(src_offline, k == 0);
    end
    rd(err_off, d);
    chk(d[2:0], 3'h5);
    $display("done: tape");
    do_reset();
    for (k = 0; k < 4; k++) begin
      rd(8'(k * 4), d);
      chk(d, (k == 0) ? ctrl_reset_val : 32'h0);
    end
    axi_rd(8'h10, d, r);
    chk(r, axi_slverr);
    axi_wr(8'h10, 32'h0, r);
    chk(r, axi_slverr);
    $display("done: reset");
    for (k = 2; k >= 0; k--) begin
      do_reset();
      {hammer_parity_err, buf_parity_err, rate_err} <= 3'h4 >> k;
      repeat (4) @(posedge aclk);
      {hammer_parity_err, buf_parity_err, rate_err} <= 3'h0;
      rd(err_off, d);
      chk(d[1:0], (k == 0) ? 2'h1 : 2'h2);
    end
    repeat (8) @(posedge aclk);
    rd(err_off, d);
    chk(d[0], 1'b1);
    wr(cmd_off, 32'h0000_0001);
    rd(err_off, d);
    chk(d[0], 1'b0);
    $display("done: errors");
    wr(ctrl_off, 32'h0000_0031);
    upspace_busy <= 1'b1;
    bp = n_term;
    bs = n_start;
    wr(cmd_off, 32'h0000_0001);
    wr(cmd_off, 32'h0000_0008);
    wait_cnt(n_term, bp);
    chk(n_term - bp, 1);
    repeat (10) @(posedge aclk);
    chk(n_start - bs, 0);
    upspace_busy <= 1'b0;
    wait_cnt(n_start, bs);
    chk(n_start - bs, 1);
    bp = n_eor;
    line_printed <= 1'b1;
    @(posedge aclk);
    line_printed <= 1'b0;
    fetch_done <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(n_eor - bp, 0);
    fetch_done <= 1'b0;
    line_printed <= 1'b1;
    @(posedge aclk);
    line_printed <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(n_eor - bp, 1);
    wr(ctrl_off, 32'h0000_0021);
    bp = n_term;
    wr(cmd_off, 32'h0000_0008);
    repeat (6) @(posedge aclk);
    chk(n_term - bp, 0);
    wr(cmd_off, 32'h0000_0004);
    wait_cnt(n_term, bp);
    chk(n_term - bp, 1);
    $display("done: line");
    bp = n_pr;
    bs = n_sp;
    wr(cmd_off, 32'h0000_0002);
    wait_off(1'b1);
    send(6'h11, 6'h12, 1'b1, 1'b0);
    wait_cnt(n_sp, bs);
    chk(n_pr - bp, 2);
    chk(last_sp, 4'h1);
    card_hopper_empty <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(src_offline, 1'b1);
    card_eof_enable <= 1'b1;
    wait_off(1'b0);
    chk(src_offline, 1'b0);
    $display("done: card");
    report_and_stop();
  end
endmodule : offline_line_printer_control_tb_top
